/* File: intc_pkg.sv */
package intc_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] FLAGS_OFFSET   = 8'h88;
    localparam logic [7:0] ENABLE_OFFSET  = 8'hA8;
    localparam logic [7:0] PRIO_OFFSET    = 8'hB8;
    localparam logic [7:0] CTRL_OFFSET    = 8'hC8;
    localparam logic [7:0] SERVICE_OFFSET = 8'hD0;

    localparam logic [7:0] FLAGS_RESET  = 8'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] PRIO_RESET   = 8'h00;
    localparam logic [7:0] CTRL_RESET   = 8'h00;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int GLOBAL_ENABLE_BIT = 7;
    localparam int NUM_SRC           = 6;
    localparam int FLAG_EXT0         = 0;
    localparam int FLAG_TIMER0       = 1;
    localparam int FLAG_EXT1         = 2;
    localparam int FLAG_TIMER1       = 3;
    localparam int FLAG_RX           = 4;
    localparam int FLAG_TX           = 5;
    localparam int FLAG_TIMER2       = 6;
    localparam int FLAG_RELOAD       = 7;
    localparam int CTRL_TRIG0        = 0;
    localparam int CTRL_TRIG1        = 1;
    localparam int CTRL_RELOAD_EN    = 2;

    // ****************************************
    // Machine cycle timing
    // ****************************************
    // One pclk per oscillator period
    localparam int         MC_PCLKS   = 12;
    localparam int         STATE5_PHASE2_COUNT = 9;
    localparam logic [1:0] CALL_MCS   = 2'h2;

    localparam logic [15:0] VECTOR_BASE = 16'h0003;
    localparam logic [15:0] VECTOR_STEP = 16'h0008;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic instr_final;
        logic return_from_interrupt;
    } core_status_t;

    typedef struct packed {
        logic        active;
        logic        push_pc;
        logic [15:0] vector;
    } call_t;

    typedef struct packed {
        logic timer0_ovf;
        logic timer1_ovf;
        logic timer2_ovf;
        logic rx_done;
        logic tx_done;
    } src_events_t;

    typedef struct packed {
        logic       valid;
        logic       high;
        logic [2:0] idx;
    } pick_t;

    // ****************************************
    // Shared functions
    // ****************************************
    function automatic logic [NUM_SRC-1:0] src_of(input logic [7:0] f);
        src_of = {f[FLAG_TIMER2] | f[FLAG_RELOAD], f[FLAG_RX] | f[FLAG_TX],
                  f[FLAG_TIMER1], f[FLAG_EXT1], f[FLAG_TIMER0], f[FLAG_EXT0]};
    endfunction : src_of

    function automatic pick_t pick(input logic [NUM_SRC-1:0] pend,
                                   input logic [NUM_SRC-1:0] lvl);
        logic [NUM_SRC-1:0] hi;
        logic [NUM_SRC-1:0] use_set;
        pick      = '0;
        hi        = pend & lvl;
        pick.high = |hi;
        use_set   = pick.high ? hi : pend;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (use_set[i]) begin
                pick.valid = 1'b1;
                pick.idx   = 3'(i);
            end
        end
    endfunction : pick

    function automatic logic [15:0] vector_of(input logic [2:0] idx);
        vector_of = VECTOR_BASE + VECTOR_STEP * {13'h0000, idx};
    endfunction : vector_of

endpackage : intc_pkg

/* File: pin_sync.sv */
`timescale 1ns/100ps
module pin_sync
    import intc_pkg::*;
#(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Pins
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] level_q
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // Idle pins rest high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q    <= '1;
            s2_q    <= '1;
            s3_q    <= '1;
            level_q <= '1;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    level_q[i] <= s3_q[i];
                end
            end
        end
    end

endmodule : pin_sync

/* File: machine_cycle_timer.sv */
`timescale 1ns/100ps
module machine_cycle_timer
    import intc_pkg::*;
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Phase pulses
    output logic      state5_phase2_q,
    output logic      mc_end_q
);

    logic [3:0] phase_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q  <= 4'h0;
            state5_phase2_q   <= 1'b0;
            mc_end_q <= 1'b0;
        end else begin
            phase_q  <= (phase_q == 4'(MC_PCLKS - 1)) ? 4'h0 : phase_q + 4'h1;
            state5_phase2_q   <= (phase_q == 4'(STATE5_PHASE2_COUNT - 1));
            mc_end_q <= (phase_q == 4'(MC_PCLKS - 2));
        end
    end

endmodule : machine_cycle_timer

/* File: two_level_interrupt_controller.sv */
// Contract
// - Priority register: one level bit per source, bits 7 and 6 read zero.
// - Level bit one selects high priority, zero selects low priority.
// - High preempts low; low never preempts low; nothing preempts high.
// - With mixed levels pending, the higher level request wins.
// - Equal level order: ext0, timer0, ext1, timer1, serial, timer2.
// - Request flags sit in one bit-addressable flag byte, set wins.
// - Flags captured at state5 phase2, polled the next machine cycle.
// - No call during equal/higher service, non-final cycle, return or enable/priority write.
// - After return or enable/priority write, one more instruction runs first.
// - Blocked requests are not remembered; each poll uses fresh captures.
// - Fixed vectors 0003h to 002Bh in steps of eight.
// - Call pushes program counter only, then loads the vector.
// - Vectoring clears external flags only in edge mode.
// - Return releases current level; plain return leaves it in service.
// - Trigger bit 0 gives low level request, 1 gives falling edge.
// - Timer2 reload flag set by pin falling edge only when enabled.
// - Hardware call lasts two machine cycles.
// - Single source latency stays above three and below nine cycles.
// - Higher request before C3 state5 phase2 vectors in C5 and C6.
// - Flags set regardless of enables; global enable gates all.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
module two_level_interrupt_controller
    import intc_pkg::*;
(
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // APB slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata_q,
    output logic              pready_q,
    output logic              pslverr_q,
    // Request pins, active low
    input  wire logic         ext0_request_pin_n,
    input  wire logic         ext1_request_pin_n,
    input  wire logic         timer2_external_pin,
    // Peripheral events
    input  wire src_events_t  events,
    // Core handshake
    input  wire core_status_t core,
    output call_t             call_q
);

    // ****************************************
    // Machine cycle and pins
    // ****************************************
    logic       state5_phase2;
    logic       mc_end;
    logic [2:0] pins;

    machine_cycle_timer u_timer (
        .pclk     (pclk),
        .presetn  (presetn),
        .state5_phase2_q   (state5_phase2),
        .mc_end_q (mc_end)
    );

    pin_sync #(.W(3)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     ({timer2_external_pin, ext1_request_pin_n, ext0_request_pin_n}),
        .level_q (pins)
    );

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic [7:0] enable_q;
    logic [7:0] prio_q;
    logic [7:0] ctrl_q;
    logic [1:0] isv_q;
    logic [2:0] samp_q;
    logic [5:0] pend_q;
    logic [5:0] poll_q;
    logic       blk_q;
    logic [1:0] call_left_q;
    logic       bus_wr;
    logic       wr_gate;
    logic [2:0] fall;
    logic [7:0] hw_set;
    logic [7:0] hw_clr;
    pick_t      win;
    logic       blocked;
    logic       start_call;

    assign bus_wr  = psel & penable & pready_q & pwrite;
    assign wr_gate = bus_wr & ((paddr == ENABLE_OFFSET) | (paddr == PRIO_OFFSET));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_q <= ENABLE_RESET;
            prio_q   <= PRIO_RESET;
            ctrl_q   <= CTRL_RESET;
        end else if (bus_wr) begin
            if (paddr == ENABLE_OFFSET) begin
                enable_q <= {pwdata[7], 1'b0, pwdata[5:0]};
            end
            if (paddr == PRIO_OFFSET) begin
                prio_q <= {2'b00, pwdata[5:0]};
            end
            if (paddr == CTRL_OFFSET) begin
                ctrl_q <= {5'h00, pwdata[2:0]};
            end
        end
    end

    // ****************************************
    // APB slave
    // ****************************************
    // No wait state; read data registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= psel & ~penable;
            pslverr_q <= 1'b0;
            if (psel & ~penable) begin
                case (paddr)
                    FLAGS_OFFSET:   prdata_q <= {24'h00_0000, flags_q};
                    ENABLE_OFFSET:  prdata_q <= {24'h00_0000, enable_q};
                    PRIO_OFFSET:    prdata_q <= {24'h00_0000, prio_q};
                    CTRL_OFFSET:    prdata_q <= {24'h00_0000, ctrl_q};
                    SERVICE_OFFSET: prdata_q <= {30'h0000_0000, isv_q};
                    default: begin
                        prdata_q  <= 32'h0000_0000;
                        pslverr_q <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Request flags
    // ****************************************
    // Pins looked at only once per machine cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            samp_q <= 3'h7;
        end else if (state5_phase2) begin
            samp_q <= pins;
        end
    end

    assign fall = {3{state5_phase2}} & samp_q & ~pins;

    always_comb begin
        hw_set = 8'h00;
        hw_clr = 8'h00;
        hw_set[FLAG_EXT0]   = fall[0] & ctrl_q[CTRL_TRIG0];
        hw_set[FLAG_EXT1]   = fall[1] & ctrl_q[CTRL_TRIG1];
        hw_set[FLAG_RELOAD] = fall[2] & ctrl_q[CTRL_RELOAD_EN];
        hw_set[FLAG_TIMER0] = events.timer0_ovf;
        hw_set[FLAG_TIMER1] = events.timer1_ovf;
        hw_set[FLAG_TIMER2] = events.timer2_ovf;
        hw_set[FLAG_RX]     = events.rx_done;
        hw_set[FLAG_TX]     = events.tx_done;
        hw_clr[FLAG_EXT0]   = start_call & (win.idx == 3'h0) & ctrl_q[CTRL_TRIG0];
        hw_clr[FLAG_EXT1]   = start_call & (win.idx == 3'h2) & ctrl_q[CTRL_TRIG1];
    end

    // Hardware set wins over any clear in the same cycle
    always_comb begin
        flags_d = flags_q;
        if (bus_wr && paddr == FLAGS_OFFSET) begin
            flags_d = pwdata[7:0];
        end
        flags_d = (flags_d & ~hw_clr) | hw_set;
        if (state5_phase2 && !ctrl_q[CTRL_TRIG0]) begin
            flags_d[FLAG_EXT0] = ~pins[0];
        end
        if (state5_phase2 && !ctrl_q[CTRL_TRIG1]) begin
            flags_d[FLAG_EXT1] = ~pins[1];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= FLAGS_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

    // Fresh capture every cycle, nothing kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= 6'h00;
        end else if (state5_phase2) begin
            pend_q <= src_of(flags_d) & enable_q[5:0]
                      & {6{enable_q[GLOBAL_ENABLE_BIT]}};
        end
    end

    // Polled set is last cycle's capture, so a call never starts in the capture cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            poll_q <= 6'h00;
        end else if (mc_end) begin
            poll_q <= pend_q;
        end
    end

    // ****************************************
    // Polling and blocking
    // ****************************************
    assign win     = pick(poll_q, prio_q[5:0]);
    assign blocked = blk_q | ~core.instr_final | (call_left_q == CALL_MCS)
                     | isv_q[1] | (isv_q[0] & ~win.high);
    assign start_call = mc_end & win.valid & ~blocked;

    // Clears at the end of the blocking instruction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blk_q <= 1'b0;
        end else if (core.return_from_interrupt | wr_gate) begin
            blk_q <= 1'b1;
        end else if (mc_end & core.instr_final) begin
            blk_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            isv_q <= 2'b00;
        end else begin
            if (core.return_from_interrupt) begin
                isv_q <= isv_q[1] ? {1'b0, isv_q[0]} : 2'b00;
            end
            if (start_call) begin
                isv_q[win.high] <= 1'b1;
            end
        end
    end

    // ****************************************
    // Hardware call
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            call_left_q <= 2'h0;
            call_q      <= '0;
        end else begin
            call_q.push_pc <= start_call;
            if (start_call) begin
                call_left_q   <= CALL_MCS;
                call_q.active <= 1'b1;
                call_q.vector <= vector_of(win.idx);
            end else if (mc_end && call_left_q != 2'h0) begin
                call_left_q   <= call_left_q - 2'h1;
                call_q.active <= (call_left_q != 2'h1);
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    logic [7:0] act_cnt_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_cnt_q <= 8'h00;
        end else begin
            act_cnt_q <= call_q.active ? act_cnt_q + 8'h01 : 8'h00;
        end
    end

    a_prio_reserved: assert property (
        @(posedge pclk) disable iff (!presetn) prio_q[7:6] == 2'b00)
        else $error("priority reserved bits set");

    a_no_low_preempt: assert property (
        @(posedge pclk) disable iff (!presetn)
        start_call && !win.high |-> isv_q == 2'b00)
        else $error("low request preempted a routine");

    a_high_wins: assert property (
        @(posedge pclk) disable iff (!presetn)
        start_call && |(poll_q & prio_q[5:0]) |-> win.high && prio_q[win.idx])
        else $error("low level chosen over high level");

    a_call_length: assert property (
        @(posedge pclk) disable iff (!presetn)
        $fell(call_q.active) |-> $past(act_cnt_q) == 8'(2 * MC_PCLKS - 1))
        else $error("call not two machine cycles");

    a_vector_form: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(call_q.active) |-> call_q.vector[2:0] == 3'h3
        && call_q.vector[15:6] == 10'h000 && call_q.vector[5:3] == $past(win.idx))
        else $error("bad vector address");

    a_call_gating: assert property (
        @(posedge pclk) disable iff (!presetn)
        start_call |-> !blk_q && core.instr_final && mc_end)
        else $error("call issued while blocked");

    a_edge_autoclr: assert property (
        @(posedge pclk) disable iff (!presetn)
        start_call && win.idx == 3'h0 && ctrl_q[CTRL_TRIG0] && !hw_set[FLAG_EXT0]
        |=> !flags_q[FLAG_EXT0])
        else $error("edge flag not cleared on vectoring");

    a_return_from_interrupt_release: assert property (
        @(posedge pclk) disable iff (!presetn)
        core.return_from_interrupt && !start_call && isv_q == 2'b11 |=> isv_q == 2'b01)
        else $error("return did not release the high level");

    a_global_gate: assert property (
        @(posedge pclk) disable iff (!presetn)
        state5_phase2 && !enable_q[GLOBAL_ENABLE_BIT] |=> pend_q == 6'h00)
        else $error("request passed with global enable clear");

    a_push_once: assert property (
        @(posedge pclk) disable iff (!presetn)
        call_q.push_pc |-> call_q.active ##1 !call_q.push_pc)
        else $error("push pulse malformed");

    a_poll_capture: assert property (
        @(posedge pclk) disable iff (!presetn)
        mc_end |=> poll_q == $past(pend_q))
        else $error("poll set not taken from capture");

    a_return_from_interrupt_blocks: assert property (
        @(posedge pclk) disable iff (!presetn)
        core.return_from_interrupt || wr_gate |=> !start_call)
        else $error("call right after return or write");

    a_call_on_cycle: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(call_q.active) |-> $past(mc_end))
        else $error("call not started at cycle end");

endmodule : two_level_interrupt_controller

/* File: core_model.sv */
`timescale 1ns/100ps
module core_model
    import intc_pkg::*;
(
    // Clock and reset
    input  wire logic    pclk,
    input  wire logic    presetn,
    // Bench controls
    input  wire logic    long_instr,
    input  wire logic    do_return_from_interrupt,
    // Controller side
    input  wire call_t   call_q,
    output core_status_t core
);
    // ************
    // Program flow
    // ************
    logic [15:0] pc_q;
    logic [15:0] stack_q;

    // Only the return address is stacked, status word stays put
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_q    <= 16'h0100;
            stack_q <= 16'h0000;
        end else if (call_q.push_pc) begin
            stack_q <= pc_q;
            pc_q    <= call_q.vector;
        end else if (do_return_from_interrupt) begin
            pc_q    <= stack_q;
        end
    end

    // Call cycles read final, so the end of the second call cycle counts as an instruction end
    assign core = {call_q.active | ~long_instr, do_return_from_interrupt};
endmodule : core_model

/* File: two_level_interrupt_controller_bench.sv */
`timescale 1ns/100ps
module two_level_interrupt_controller_bench
    import intc_pkg::*;
;
    // ************
    // Wiring
    // ************
    localparam logic [31:0] ONE  = 32'h0000_0001;
    localparam logic [31:0] ZERO = 32'h0000_0000;
    logic         pclk       = 1'b0;
    logic         presetn    = 1'b0;
    logic         psel       = 1'b0;
    logic         penable    = 1'b0;
    logic         pwrite     = 1'b0;
    logic [7:0]   paddr      = 8'h00;
    logic [31:0]  pwdata     = 32'h0000_0000;
    logic [31:0]  prdata_q;
    logic         pready_q;
    logic         pslverr_q;
    logic         ext0_n     = 1'b1;
    logic         ext1_n     = 1'b1;
    logic         t2_pin     = 1'b1;
    src_events_t  events     = '0;
    core_status_t core;
    call_t        call_q;
    logic         long_instr = 1'b0;
    logic         do_return_from_interrupt    = 1'b0;
    logic         err;
    logic [31:0]  r;
    int           lat;
    int           failures   = 0;
    int           n_compared = 0;
    int           cycles     = 0;

    always #20 pclk = ~pclk;

    two_level_interrupt_controller i_two_level_interrupt_controller (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata_q, .pready_q, .pslverr_q, .ext0_request_pin_n(ext0_n),
        .ext1_request_pin_n(ext1_n), .timer2_external_pin(t2_pin),
        .events, .core, .call_q);
    core_model i_core_model (.pclk, .presetn, .long_instr, .do_return_from_interrupt,
                             .call_q, .core);

    // ************
    // Shared tasks
    // ************
    task automatic conclude;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready_q !== 1'b1);
        r       = prdata_q;
        err     = pslverr_q;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        check(r, {24'h00_0000, exp});
    endtask : rd

    task automatic pulse(input src_events_t v);
        @(posedge pclk);
        events <= v;
        @(posedge pclk);
        events <= '0;
    endtask : pulse

    task automatic ret_int;
        @(posedge pclk);
        do_return_from_interrupt <= 1'b1;
        @(posedge pclk);
        do_return_from_interrupt <= 1'b0;
    endtask : ret_int

    // Whole call: vector, push pulse and its length in pclk
    task automatic get_call(input logic [15:0] vec);
        int n;
        lat = 0;
        n   = 0;
        while (call_q.active !== 1'b1 && lat < 300) begin
            @(negedge pclk);
            lat++;
        end
        check({16'h0000, call_q.vector}, {16'h0000, vec});
        check(32'(call_q.push_pc), ONE);
        while (call_q.active === 1'b1 && n < 40) begin
            @(negedge pclk);
            n++;
        end
        check(32'(n), 32'(CALL_MCS * MC_PCLKS));
    endtask : get_call

    task automatic no_call(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(negedge pclk);
            seen = seen | call_q.active;
        end
        check(32'(seen), ZERO);
    endtask : no_call

    // ************
    // Scenarios
    // ************
    task automatic s_regs;
        rd(PRIO_OFFSET, 8'h00);
        wr(PRIO_OFFSET, 8'hFF);
        rd(PRIO_OFFSET, 8'h3F);
        apb(1'b0, 8'h90, 8'h00);
        check(32'(err), ONE);
        wr(PRIO_OFFSET, 8'h00);
    endtask : s_regs

    task automatic s_single;
        wr(ENABLE_OFFSET, 8'h82);
        pulse(5'h10);
        get_call(16'h000B);
        check(32'(lat + 24 > 3 * MC_PCLKS && lat + 24 < 9 * MC_PCLKS), ONE);
        rd(FLAGS_OFFSET, 8'h02);
        rd(SERVICE_OFFSET, 8'h01);
        wr(FLAGS_OFFSET, 8'h00);
        ret_int();
        rd(SERVICE_OFFSET, 8'h00);
    endtask : s_single

    task automatic s_order;
        wr(CTRL_OFFSET, 8'h03);
        wr(ENABLE_OFFSET, 8'hBF);
        wr(FLAGS_OFFSET, 8'h5F);
        for (int i = 0; i < 6; i++) begin
            get_call(16'h0003 + 16'(8 * i));
            if (i == 0) begin
                rd(FLAGS_OFFSET, 8'h5E);
            end
            wr(FLAGS_OFFSET, i == 5 ? 8'h00 : 8'h5F & (8'hFF << (i + 1)));
            ret_int();
        end
        rd(SERVICE_OFFSET, 8'h00);
    endtask : s_order

    task automatic s_prio;
        wr(PRIO_OFFSET, 8'h20);
        wr(FLAGS_OFFSET, 8'h41);
        get_call(16'h002B);
        rd(SERVICE_OFFSET, 8'h02);
        no_call(48);
        wr(FLAGS_OFFSET, 8'h01);
        ret_int();
        get_call(16'h0003);
        wr(FLAGS_OFFSET, 8'h42);
        get_call(16'h002B);
        check(32'(lat < 3 * MC_PCLKS), ONE);
        rd(SERVICE_OFFSET, 8'h03);
        wr(FLAGS_OFFSET, 8'h02);
        ret_int();
        no_call(48);
        rd(SERVICE_OFFSET, 8'h01);
        wr(FLAGS_OFFSET, 8'h00);
        ret_int();
        rd(SERVICE_OFFSET, 8'h00);
    endtask : s_prio

    task automatic s_block;
        wr(ENABLE_OFFSET, 8'h3F);
        pulse(5'h08);
        rd(FLAGS_OFFSET, 8'h08);
        no_call(48);
        wr(FLAGS_OFFSET, 8'h00);
        wr(ENABLE_OFFSET, 8'hBF);
        no_call(48);
        @(posedge pclk);
        long_instr <= 1'b1;
        pulse(5'h08);
        no_call(48);
        @(posedge pclk);
        long_instr <= 1'b0;
        get_call(16'h001B);
        wr(FLAGS_OFFSET, 8'h00);
        ret_int();
    endtask : s_block

    task automatic s_ext;
        wr(CTRL_OFFSET, 8'h00);
        @(posedge pclk);
        ext1_n <= 1'b0;
        get_call(16'h0013);
        @(posedge pclk);
        ext1_n <= 1'b1;
        repeat (36) @(posedge pclk);
        rd(FLAGS_OFFSET, 8'h00);
        ret_int();
        no_call(48);
        wr(CTRL_OFFSET, 8'h01);
        @(posedge pclk);
        ext0_n <= 1'b0;
        get_call(16'h0003);
        rd(FLAGS_OFFSET, 8'h00);
        @(posedge pclk);
        ext0_n <= 1'b1;
        ret_int();
        // Reload edges flagged only with reload enabled, calls kept off
        wr(ENABLE_OFFSET, 8'h00);
        @(posedge pclk);
        t2_pin <= 1'b0;
        repeat (36) @(posedge pclk);
        rd(FLAGS_OFFSET, 8'h00);
        t2_pin <= 1'b1;
        wr(CTRL_OFFSET, 8'h04);
        repeat (36) @(posedge pclk);
        t2_pin <= 1'b0;
        repeat (36) @(posedge pclk);
        rd(FLAGS_OFFSET, 8'h80);
    endtask : s_ext

    // ************
    // Run
    // ************
    // Whole run needs well under half of this
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        s_regs();
        s_single();
        s_order();
        s_prio();
        s_block();
        s_ext();
        conclude();
    end
endmodule : two_level_interrupt_controller_bench
